// [blit_order_pkg.sv]
// Constants and state encoding for the display-list order executor
package blit_order_pkg;

   // ----------------------------------------------------------------
   // Order codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_EXP_HT_BLIT = 8'h27;
   localparam logic [7:0] OP_BRANCH = 8'h01;
   localparam logic [7:0] RESERVED_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // Order layout in 16-bit words, opcode in the high byte of word 0
   // ----------------------------------------------------------------
   localparam logic [3:0] BLIT_WORDS = 4'd13;
   localparam logic [3:0] BRANCH_WORDS = 4'd3;
   localparam int IX_OPC = 0;
   localparam int IX_DA = 1;
   localparam int IX_FW = 3;
   localparam int IX_FH = 4;
   localparam int IX_SA = 5;
   localparam int IX_SW = 7;
   localparam int IX_MUL = 8;
   localparam int IX_HXR = 9;
   localparam int IX_HYR = 10;
   localparam int IX_HA = 11;
   localparam int IX_TGT = 1;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 8;
   localparam int RSV_HI = 7;
   localparam int RSV_LO = 0;

   // ----------------------------------------------------------------
   // Scale and clip fields of the multiplier word
   // ----------------------------------------------------------------
   localparam int X_CLIP_OFFSET_HI = 15;
   localparam int X_CLIP_OFFSET_LO = 12;
   localparam int X_SCALE_MULTIPLIER_HI = 11;
   localparam int X_SCALE_MULTIPLIER_LO = 8;
   localparam int Y_CLIP_OFFSET_HI = 7;
   localparam int Y_CLIP_OFFSET_LO = 4;
   localparam int Y_SCALE_MULTIPLIER_HI = 3;
   localparam int Y_SCALE_MULTIPLIER_LO = 0;
   // One bit per horizontal multiplier code; a cleared bit means no X scaling
   localparam logic [15:0] X_SCALE_MULTIPLIER_SUPPORTED = 16'hFFFF;

   // ----------------------------------------------------------------
   // Address handling
   // ----------------------------------------------------------------
   localparam int LIST_ADDR_W = 28;
   localparam logic [27:0] LIST_WORD_STEP = 28'h000_0002;
   localparam logic [27:0] BRANCH_ALIGN_MASK = 28'hFFF_FFFE;
   localparam logic [31:0] BIT_STEP = 32'h0000_0001;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [3:0] REP_ONE = 4'h1;
   localparam logic [3:0] REP_ZERO = 4'h0;

   // ----------------------------------------------------------------
   // Executor states
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_FETCH = 8'b0000_0010,
      ST_EXEC = 8'b0000_0100,
      ST_SRC = 8'b0000_1000,
      ST_HT = 8'b0001_0000,
      ST_DST = 8'b0010_0000,
      ST_WRITE = 8'b0100_0000,
      ST_STEP = 8'b1000_0000
   } exec_state_t;

endpackage

// [expanded_halftone_blit_orders.sv]
// Display-list executor for the expanded halftone blit order and the branch order
// Operation
// - Blit order: 0x27, zero byte, then parameters; thirteen words in all.
// - Expand source, combine with halftone and destination by the three-operand code.
// - Halftone wraps at its right and bottom edges, tiling the frame.
// - Frame no larger than expanded source; smaller frames use only part.
// - Source starts upper left; source warp advances each source scanline.
// - Warp from the source bitmap setup is ignored for this order.
// - X multiplier low nibble, codes 0-15; unsupported codes mean no X scaling.
// - X offset high nibble skips that many leftmost expanded bits.
// - Y multiplier low nibble accepts every code 0-15 as factor 1-16.
// - Y offset high nibble skips that many top expanded scanlines.
// - Branch order: 0x01, zero byte, then 28-bit target byte address.
// - Branch loads the list pointer with the target and fetches there.
// - Branch target least significant bit is forced to zero.
`timescale 1ns/1ns

module expanded_halftone_blit_orders
   import blit_order_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [27:0] listStartAddr,
   input wire logic [15:0] destinationWarp,
   input wire logic [15:0] halftoneWidth,
   input wire logic [15:0] halftoneHeight,
   input wire logic [7:0] booleanCode,
   output logic busy,
   output logic done,
   output logic orderError,
   output logic [27:0] listPointer,
   output logic memReq,
   output logic [27:0] memAddr,
   input wire logic [15:0] memRData,
   input wire logic memAck,
   output logic bitReq,
   output logic bitWe,
   output logic [31:0] bitAddr,
   output logic bitWData,
   input wire logic bitRData,
   input wire logic bitAck
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   exec_state_t state_q;
   logic [15:0] param_q [0:13];
   logic [3:0] wordIdx_q;
   logic [27:0] ptr_q;
   logic done_q;
   logic error_q;
   logic [31:0] destRow_q;
   logic [31:0] destBit_q;
   logic [31:0] srcRow_q;
   logic [31:0] srcBit_q;
   logic [31:0] htTop_q;
   logic [31:0] htRow_q;
   logic [31:0] htBit_q;
   logic [31:0] htColOff_q;
   logic [15:0] hxRem_q;
   logic [15:0] hyRem_q;
   logic [15:0] colLeft_q;
   logic [15:0] rowLeft_q;
   logic [3:0] xRep_q;
   logic [3:0] yRep_q;
   logic srcPix_q;
   logic htPix_q;
   logic wData_q;

   // ----------------------------------------------------------------
   // Decode of the stored order
   // ----------------------------------------------------------------
   logic [7:0] opcode;
   logic [7:0] fetchOpcode;
   logic [3:0] needWords;
   logic [3:0] xMulRaw;
   logic [3:0] xMulEff;
   logic [3:0] x_clip_offset;
   logic [3:0] y_scale_multiplier;
   logic [3:0] y_clip_offset;
   logic [31:0] daParam;
   logic [31:0] saParam;
   logic [31:0] haParam;
   logic [31:0] htRowStart;
   logic [31:0] htLinesAbove;
   logic [31:0] branchTarget;
   logic lastCol;
   logic lastRow;
   logic [31:0] nextDestRow;
   logic [31:0] nextSrcRow;
   logic [31:0] nextHtRow;

   assign opcode = param_q[IX_OPC][OPC_HI:OPC_LO];
   assign fetchOpcode = (wordIdx_q == REP_ZERO) ? memRData[OPC_HI:OPC_LO] : opcode;
   // The reserved byte is not checked; only the opcode selects the length
   assign needWords = (fetchOpcode == OP_EXP_HT_BLIT) ? BLIT_WORDS :
                      (fetchOpcode == OP_BRANCH) ? BRANCH_WORDS : REP_ZERO;
   assign xMulRaw = param_q[IX_MUL][X_SCALE_MULTIPLIER_HI:X_SCALE_MULTIPLIER_LO];
   assign xMulEff = X_SCALE_MULTIPLIER_SUPPORTED[xMulRaw] ? xMulRaw : REP_ZERO;
   assign x_clip_offset = param_q[IX_MUL][X_CLIP_OFFSET_HI:X_CLIP_OFFSET_LO];
   assign y_scale_multiplier = param_q[IX_MUL][Y_SCALE_MULTIPLIER_HI:Y_SCALE_MULTIPLIER_LO];
   assign y_clip_offset = param_q[IX_MUL][Y_CLIP_OFFSET_HI:Y_CLIP_OFFSET_LO];
   assign daParam = {param_q[IX_DA], param_q[IX_DA + 1]};
   assign saParam = {param_q[IX_SA], param_q[IX_SA + 1]};
   assign haParam = {param_q[IX_HA], param_q[IX_HA + 1]};
   assign branchTarget = {param_q[IX_TGT], param_q[IX_TGT + 1]};
   // Halftone row start and top of the tile, located from the remainders
   assign htRowStart = haParam - {16'h0000, halftoneWidth - param_q[IX_HXR]};
   assign htLinesAbove = {16'h0000, halftoneHeight - param_q[IX_HYR]} *
                         {16'h0000, halftoneWidth};
   assign lastCol = (colLeft_q == COUNT_ONE);
   assign lastRow = (rowLeft_q == COUNT_ONE);
   assign nextDestRow = destRow_q + {16'h0000, destinationWarp};
   // Only the order's own warp steps the source, never the source setup warp
   assign nextSrcRow = (yRep_q == y_scale_multiplier) ?
                       srcRow_q + {16'h0000, param_q[IX_SW]} : srcRow_q;
   assign nextHtRow = (hyRem_q == COUNT_ONE) ? htTop_q :
                      htRow_q + {16'h0000, halftoneWidth};

   // ----------------------------------------------------------------
   // Order fetch, dispatch and sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         wordIdx_q <= REP_ZERO;
         ptr_q <= '0;
         done_q <= 1'b0;
         error_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         error_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  ptr_q <= listStartAddr;
                  wordIdx_q <= REP_ZERO;
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (memAck) begin
                  ptr_q <= ptr_q + LIST_WORD_STEP;
                  if (needWords == REP_ZERO) begin
                     error_q <= 1'b1;
                     done_q <= 1'b1;
                     state_q <= ST_IDLE;
                  end else if (wordIdx_q + REP_ONE == needWords) begin
                     wordIdx_q <= REP_ZERO;
                     state_q <= ST_EXEC;
                  end else begin
                     wordIdx_q <= wordIdx_q + REP_ONE;
                  end
               end
            end
            ST_EXEC: begin
               if (opcode == OP_BRANCH) begin
                  ptr_q <= branchTarget[LIST_ADDR_W-1:0] & BRANCH_ALIGN_MASK;
                  state_q <= ST_FETCH;
               end else if (param_q[IX_FW] == '0 || param_q[IX_FH] == '0) begin
                  state_q <= ST_FETCH;
               end else begin
                  state_q <= ST_SRC;
               end
            end
            ST_SRC: begin
               if (bitAck) begin
                  state_q <= ST_HT;
               end
            end
            ST_HT: begin
               if (bitAck) begin
                  state_q <= ST_DST;
               end
            end
            ST_DST: begin
               if (bitAck) begin
                  state_q <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (bitAck) begin
                  state_q <= ST_STEP;
               end
            end
            ST_STEP: begin
               state_q <= (lastCol && lastRow) ? ST_FETCH : ST_SRC;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Parameter capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 14; i++) begin
            param_q[i] <= '0;
         end
      end else if (state_q == ST_FETCH && memAck) begin
         param_q[wordIdx_q] <= memRData;
      end
   end

   // ----------------------------------------------------------------
   // Pixel operands and Boolean combine
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         srcPix_q <= 1'b0;
         htPix_q <= 1'b0;
         wData_q <= 1'b0;
      end else if (bitAck) begin
         if (state_q == ST_SRC) begin
            srcPix_q <= bitRData;
         end
         if (state_q == ST_HT) begin
            htPix_q <= bitRData;
         end
         if (state_q == ST_DST) begin
            wData_q <= booleanCode[{srcPix_q, htPix_q, bitRData}];
         end
      end
   end

   // ----------------------------------------------------------------
   // Destination and source walkers with scaling and clipping
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         destRow_q <= '0;
         destBit_q <= '0;
         srcRow_q <= '0;
         srcBit_q <= '0;
         xRep_q <= REP_ZERO;
         yRep_q <= REP_ZERO;
         colLeft_q <= '0;
         rowLeft_q <= '0;
      end else if (state_q == ST_EXEC) begin
         destRow_q <= daParam;
         destBit_q <= daParam;
         srcRow_q <= saParam;
         srcBit_q <= saParam;
         xRep_q <= x_clip_offset;
         yRep_q <= y_clip_offset;
         colLeft_q <= param_q[IX_FW];
         rowLeft_q <= param_q[IX_FH];
      end else if (state_q == ST_STEP) begin
         if (lastCol) begin
            destRow_q <= nextDestRow;
            destBit_q <= nextDestRow;
            srcRow_q <= nextSrcRow;
            srcBit_q <= nextSrcRow;
            yRep_q <= (yRep_q == y_scale_multiplier) ? REP_ZERO : yRep_q + REP_ONE;
            xRep_q <= x_clip_offset;
            colLeft_q <= param_q[IX_FW];
            rowLeft_q <= rowLeft_q - COUNT_ONE;
         end else begin
            destBit_q <= destBit_q + BIT_STEP;
            colLeft_q <= colLeft_q - COUNT_ONE;
            if (xRep_q == xMulEff) begin
               xRep_q <= REP_ZERO;
               srcBit_q <= srcBit_q + BIT_STEP;
            end else begin
               xRep_q <= xRep_q + REP_ONE;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Halftone walker with tiling
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         htTop_q <= '0;
         htRow_q <= '0;
         htBit_q <= '0;
         htColOff_q <= '0;
         hxRem_q <= '0;
         hyRem_q <= '0;
      end else if (state_q == ST_EXEC) begin
         htTop_q <= htRowStart - htLinesAbove;
         htRow_q <= htRowStart;
         htBit_q <= haParam;
         htColOff_q <= {16'h0000, halftoneWidth - param_q[IX_HXR]};
         hxRem_q <= param_q[IX_HXR];
         hyRem_q <= param_q[IX_HYR];
      end else if (state_q == ST_STEP) begin
         if (lastCol) begin
            htRow_q <= nextHtRow;
            htBit_q <= nextHtRow + htColOff_q;
            hxRem_q <= param_q[IX_HXR];
            hyRem_q <= (hyRem_q == COUNT_ONE) ? halftoneHeight : hyRem_q - COUNT_ONE;
         end else if (hxRem_q == COUNT_ONE) begin
            htBit_q <= htRow_q;
            hxRem_q <= halftoneWidth;
         end else begin
            htBit_q <= htBit_q + BIT_STEP;
            hxRem_q <= hxRem_q - COUNT_ONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign busy = (state_q != ST_IDLE);
   assign done = done_q;
   assign orderError = error_q;
   assign listPointer = ptr_q;
   assign memReq = (state_q == ST_FETCH);
   assign memAddr = ptr_q;
   assign bitReq = (state_q == ST_SRC) || (state_q == ST_HT) ||
                   (state_q == ST_DST) || (state_q == ST_WRITE);
   assign bitWe = (state_q == ST_WRITE);
   assign bitWData = wData_q;
   assign bitAddr = (state_q == ST_SRC) ? srcBit_q :
                    (state_q == ST_HT) ? htBit_q : destBit_q;

endmodule

// [blit_order_chk.sv]
// Concurrent checks on the order executor ports
`timescale 1ns/1ns
module blit_order_chk (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic busy,
   input wire logic done,
   input wire logic orderError,
   input wire logic memReq,
   input wire logic [27:0] memAddr,
   input wire logic memAck,
   input wire logic bitReq,
   input wire logic bitWe,
   input wire logic [31:0] bitAddr,
   input wire logic bitWData,
   input wire logic bitAck
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_fetch_hold: assert property (
      memReq && !memAck |=> memReq && $stable(memAddr))
      else $error("fetch request dropped or moved before ack");
   chk_fetch_step: assert property (
      memReq && memAck |=> memAddr == $past(memAddr) + 28'h000_0002)
      else $error("fetch address did not advance by one word");
   chk_fetch_even: assert property (memReq |-> !memAddr[0])
      else $error("odd fetch address");
   chk_bit_hold: assert property (
      bitReq && !bitAck |=> bitReq && $stable(bitAddr) && $stable(bitWe) && $stable(bitWData))
      else $error("bit access changed before ack");
   chk_pixel_gap: assert property (bitReq && bitWe && bitAck |=> !bitReq)
      else $error("no step cycle after pixel write");
   chk_port_excl: assert property (!(memReq && bitReq))
      else $error("fetch and bit access together");
   chk_busy_covers: assert property (memReq || bitReq |-> busy)
      else $error("access while not busy");
   chk_error_pulse: assert property (done |-> orderError ##1 !done)
      else $error("halt pulse malformed");

   cover property (memReq && memAck);
   cover property (bitReq && bitWe && bitAck);
   cover property (done && orderError);
endmodule

bind expanded_halftone_blit_orders blit_order_chk i_blit_order_chk (.clk_sys, .reset_n,
   .busy, .done, .orderError, .memReq, .memAddr, .memAck, .bitReq, .bitWe, .bitAddr,
   .bitWData, .bitAck);

// [blit_mem_model.sv]
// Display list and bitmap memory answering the executor
`timescale 1ns/1ns
module blit_mem_model (
   input wire logic clk_sys,
   input wire logic [3:0] slowCycles,
   input wire logic memReq,
   input wire logic [27:0] memAddr,
   output logic [15:0] memRData,
   output logic memAck,
   input wire logic bitReq,
   input wire logic bitWe,
   input wire logic [31:0] bitAddr,
   input wire logic bitWData,
   output logic bitRData,
   output logic bitAck
);
   logic [15:0] listMem [0:255];
   logic bitMem [0:4095];
   logic [3:0] memWait = 4'h0;
   logic [3:0] bitWait = 4'h0;
   logic [27:0] lastAddr = 28'h000_0000;
   int writes = 0;
   initial memRData = 16'h0000;
   initial memAck = 1'b0;
   initial bitRData = 1'b0;
   initial bitAck = 1'b0;

   // Read data toggles when not answered so stale values never match
   always @(posedge clk_sys) begin
      memAck <= 1'b0;
      memRData <= ~memRData;
      if (memReq && !memAck) begin
         if (memWait == slowCycles) begin
            memAck <= 1'b1;
            memRData <= listMem[memAddr[8:1]];
            lastAddr <= memAddr;
            memWait <= 4'h0;
         end else begin
            memWait <= memWait + 4'h1;
         end
      end
   end

   always @(posedge clk_sys) begin
      bitAck <= 1'b0;
      bitRData <= ~bitRData;
      if (bitReq && !bitAck) begin
         if (bitWait == slowCycles) begin
            bitAck <= 1'b1;
            bitWait <= 4'h0;
            if (bitWe) begin
               bitMem[bitAddr[11:0]] <= bitWData;
               writes <= writes + 1;
            end else begin
               bitRData <= bitMem[bitAddr[11:0]];
            end
         end else begin
            bitWait <= bitWait + 4'h1;
         end
      end
   end
endmodule

// [expanded_halftone_blit_orders_tb.sv]
// Self-checking bench for the order executor
`timescale 1ns/1ns
module expanded_halftone_blit_orders_tb;
   import blit_order_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic start = 1'b0;
   logic [27:0] listStartAddr = 28'h000_0000;
   logic [15:0] destinationWarp = 16'h0010;
   logic [15:0] halftoneWidth = 16'h0003;
   logic [15:0] halftoneHeight = 16'h0002;
   logic [7:0] booleanCode = 8'h6A;
   logic [3:0] slowCycles = 4'h0;
   logic busy, done, orderError, memReq, memAck, bitReq, bitWe, bitWData, bitRData, bitAck;
   logic [27:0] listPointer, memAddr;
   logic [15:0] memRData;
   logic [31:0] bitAddr;
   logic image [0:4095];
   // Frame 4x3 at 0x800, X factor 2 clip 1, Y factor 3 clip 2, tile 3x2 from row 1 col 1
   logic [15:0] blitWords [13] = '{16'h2700, 16'h0000, 16'h0800, 16'h0004, 16'h0003,
      16'h0000, 16'h0100, 16'h0008, 16'h1122, 16'h0002, 16'h0001, 16'h0000, 16'h0304};
   int fails = 0;
   int checks_done = 0;

   always #50 clk_sys = ~clk_sys;

   expanded_halftone_blit_orders i_expanded_halftone_blit_orders (.clk_sys, .reset_n, .start,
      .listStartAddr, .destinationWarp, .halftoneWidth, .halftoneHeight, .booleanCode, .busy,
      .done, .orderError, .listPointer, .memReq, .memAddr, .memRData, .memAck, .bitReq,
      .bitWe, .bitAddr, .bitWData, .bitRData, .bitAck);
   blit_mem_model i_blit_mem_model (.clk_sys, .slowCycles, .memReq, .memAddr, .memRData,
      .memAck, .bitReq, .bitWe, .bitAddr, .bitWData, .bitRData, .bitAck);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      if (fails == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic put(input logic [27:0] a, input logic [15:0] w);
      i_blit_mem_model.listMem[a[8:1]] = w;
   endtask

   task automatic loadBlit(input logic [27:0] base);
      for (int k = 0; k < 13; k++) put(base + 28'(2 * k), blitWords[k]);
   endtask

   // Starts at a, optionally pokes a second start while busy, waits for the halt
   task automatic runTo(input logic [27:0] a, input logic poke);
      int n;
      @(negedge clk_sys);
      start = 1'b1;
      listStartAddr = a;
      @(negedge clk_sys);
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
         @(negedge clk_sys);
         n++;
         if (n == 3) start = poke;
         if (n == 3) listStartAddr = 28'h000_0300;
         if (n == 4) start = 1'b0;
      end
      if (n == 5000) begin
         fails++;
         summarize();
      end
      check(orderError, 1'b1);
      check(busy, 1'b0);
   endtask

   task automatic blitScenario;
      logic s, h;
      int a;
      for (a = 0; a < 4096; a++) begin
         image[a] = a[0] ^ a[2] ^ a[5];
         i_blit_mem_model.bitMem[a] = image[a];
      end
      loadBlit(28'h000_0100);
      put(28'h000_011A, {OP_BRANCH, RESERVED_BYTE});
      put(28'h000_011C, 16'h0000);
      put(28'h000_011E, 16'h0201);
      put(28'h000_0200, 16'hFF00);
      for (int r = 0; r < 3; r++) begin
         for (int c = 0; c < 4; c++) begin
            s = image[32'h100 + ((r + 2) / 3) * 8 + (c + 1) / 2];
            h = image[32'h300 + ((r + 1) % 2) * 3 + (c + 1) % 3];
            a = 32'h800 + r * 16 + c;
            image[a] = booleanCode[{s, h, image[a]}];
         end
      end
      runTo(28'h000_0100, 1'b0);
      check(i_blit_mem_model.lastAddr, 28'h000_0200);
      check(listPointer, 28'h000_0202);
      check(i_blit_mem_model.writes, 12);
      for (a = 32'h7F0; a < 32'h840; a++) begin
         check(i_blit_mem_model.bitMem[a], image[a]);
      end
   endtask

   task automatic slowScenario;
      slowCycles = 4'h3;
      put(28'h000_0040, {OP_BRANCH, RESERVED_BYTE});
      put(28'h000_0042, 16'h0000);
      put(28'h000_0044, 16'h00A1);
      loadBlit(28'h000_00A0);
      put(28'h000_00A8, 16'h0000);
      put(28'h000_00BA, 16'hFF00);
      runTo(28'h000_0040, 1'b1);
      check(i_blit_mem_model.lastAddr, 28'h000_00BA);
      check(listPointer, 28'h000_00BC);
      check(i_blit_mem_model.writes, 12);
      check(i_blit_mem_model.bitMem[32'h800], image[32'h800]);
   endtask

   initial begin
      repeat (2) @(negedge clk_sys);
      reset_n = 1'b1;
      blitScenario();
      slowScenario();
      summarize();
   end
endmodule
